// file: rtl/twm_pkg.sv
// Package of constants and types for the two-wire master receiver
package twm_pkg;

    // Register offsets on the plain register port
    localparam logic [1:0] OFF_CTRL = 2'h0;
    localparam logic [1:0] OFF_STAT = 2'h1;
    localparam logic [1:0] OFF_DATA = 2'h2;

    // Values after reset
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] DATA_RST = 8'hFF;

    // Status codes, prescaler bits zero
    localparam logic [7:0] SC_START  = 8'h08;
    localparam logic [7:0] SC_RSTART = 8'h10;
    localparam logic [7:0] SC_WA_ACK = 8'h18;
    localparam logic [7:0] SC_WA_NAK = 8'h20;
    localparam logic [7:0] SC_ARB    = 8'h38;
    localparam logic [7:0] SC_RA_ACK = 8'h40;
    localparam logic [7:0] SC_RA_NAK = 8'h48;
    localparam logic [7:0] SC_RD_ACK = 8'h50;
    localparam logic [7:0] SC_RD_NAK = 8'h58;
    localparam logic [7:0] SC_IDLE   = 8'hF8;

    // Bus timing: one quarter of a bit period
    localparam int CLK_NS  = 50;
    localparam int QUAR_NS = 2500;
    localparam int Q_CYC   = (QUAR_NS + CLK_NS - 1) / CLK_NS;

    // Bit engine positions
    localparam logic [3:0] ACK_BIT = 4'h8;
    localparam logic [1:0] PH_LAST = 2'h3;

    // Layout of the bus_control register
    typedef struct packed {
        logic flag;      // step_done_flag
        logic ack_en;    // ack_enable
        logic start;     // start_request
        logic stop;      // stop_request
        logic wcol;      // write_collision_flag
        logic en;        // interface_enable
        logic rsvd;      // Reads as zero
        logic ie;        // interrupt_enable
    } twm_ctrl_t;

    // Sequencer states
    typedef enum logic [4:0] {
        S_IDLE  = 5'b00001,
        S_START = 5'b00010,
        S_BIT   = 5'b00100,
        S_STOP  = 5'b01000,
        S_WAIT  = 5'b10000
    } twm_state_t;

endpackage : twm_pkg

// file: rtl/twm_master_rx.sv
// Two-wire master receiver with register port and open-drain pins
//
// Strobed register access and the placing of the registers were left to the implementer.
module twm_master_rx
    import twm_pkg::*;
#(
    parameter int unsigned QCYC = Q_CYC  // Clock cycles per quarter bit
)(
    input  wire logic       clk_sys,
    input  wire logic       arst_n,
    input  wire logic [1:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    output logic            irq,
    input  wire logic       scl_i,
    output logic            scl_o,
    output logic            scl_oe,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe
);

    ////////////////////////////////////////////////////////////////////
    // Declarations
    twm_state_t state_ff, nxt_state;  // Sequencer state
    twm_ctrl_t  ctrl_ff, nxt_ctrl;    // bus_control
    twm_ctrl_t  wctrl;                // Write data as control layout
    logic [1:0] sync1_ff, sync2_ff;   // Pin synchronisers {scl,sda}
    logic [1:0] prev_ff;              // Last synced pin levels
    logic       busy_ff;              // Bus owned by someone
    logic       owner_ff;             // We own the bus
    logic [1:0] ph_ff;                // Quarter within bit
    logic [15:0] cnt_ff;              // Quarter timer
    logic [3:0] bit_ff;               // Bit index, 8 is the ack slot
    logic [7:0] shreg_ff;             // Shift register
    logic       samp_ff;              // Bit sampled in this bit
    logic       addr_ff;              // Current byte is an address
    logic       rd_ff;                // Read direction selected
    logic [7:0] code_ff;              // bus_status code
    logic [1:0] presc_ff;             // Prescaler bits, stored only
    logic [7:0] data_ff;              // bus_data
    logic [7:0] rdata_ff;             // Read data
    logic       scl_oe_ff, sda_oe_ff; // Pin pull-down enables
    logic       nxt_scl_oe, nxt_sda_oe;

    ////////////////////////////////////////////////////////////////////
    // Decoding
    wire        scl_s    = sync2_ff[1];
    wire        sda_s    = sync2_ff[0];
    wire        wr_ctrl  = reg_wr && (reg_addr == OFF_CTRL);
    wire        wr_stat  = reg_wr && (reg_addr == OFF_STAT);
    wire        wr_data  = reg_wr && (reg_addr == OFF_DATA);
    wire        active   = (state_ff == S_START) || (state_ff == S_BIT)
                        || (state_ff == S_STOP);
    // Released clock only counts once the line is high: slaves may stretch
    wire        cnt_en   = scl_oe_ff || scl_s;
    // A START from an unowned bus waits for the bus to go free
    wire        start_ok = (state_ff != S_START) || owner_ff || !busy_ff;
    wire        run      = active && cnt_en && start_ok;
    wire        tick     = run && (cnt_ff == 16'(QCYC - 1));
    wire        ph_end   = tick && (ph_ff == PH_LAST);
    wire        fresh    = (ph_ff == 2'h0) && (cnt_ff == 16'h0000);
    wire        in_ack   = (bit_ff == ACK_BIT);
    // Slots where this end drives the data line
    wire        own_bit  = addr_ff ? !in_ack : in_ack;
    // Address bits from the shifter, ack slot low when ack_enable set
    wire        tx_one   = addr_ff ? shreg_ff[7] : !ctrl_ff.ack_en;
    wire        send_one = own_bit ? tx_one : 1'b1;
    wire        samp_now = (state_ff == S_BIT) && tick && (ph_ff == 2'h2);
    // Released our line but it reads low: someone else won
    wire        arb_lost = samp_now && own_bit && send_one && !sda_s;
    wire        bit_end  = (state_ff == S_BIT) && ph_end && in_ack;
    wire        strt_end = (state_ff == S_START) && ph_end;
    wire        stop_end = (state_ff == S_STOP) && ph_end;
    wire        flag_set = bit_end || arb_lost || strt_end;
    wire        go       = (state_ff == S_WAIT) && !ctrl_ff.flag;
    wire        is_addr  = (code_ff == SC_START) || (code_ff == SC_RSTART);
    wire        is_rx    = (code_ff == SC_RA_ACK) || (code_ff == SC_RD_ACK);
    wire        is_arb   = (code_ff == SC_ARB);
    wire        ld_addr  = go && is_addr;
    wire        rx_data  = bit_end && !addr_ff;
    wire [7:0]  stat_rd  = {code_ff[7:3], 1'b0, presc_ff};
    wire [7:0]  rd_mux   = (reg_addr == OFF_CTRL) ? ctrl_ff  :
                           (reg_addr == OFF_STAT) ? stat_rd  :
                           (reg_addr == OFF_DATA) ? data_ff  : 8'h00;

    assign wctrl     = twm_ctrl_t'(reg_wdata);
    assign reg_rdata = rdata_ff;
    assign irq       = ctrl_ff.flag && ctrl_ff.ie;
    assign scl_o     = 1'b0;
    assign sda_o     = 1'b0;
    assign scl_oe    = scl_oe_ff;
    assign sda_oe    = sda_oe_ff;

    ////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            S_IDLE: begin
                // Master work only ever opens with a START
                if (ctrl_ff.start && !ctrl_ff.flag) begin
                    nxt_state = S_START;
                end
            end
            S_START: begin
                if (strt_end) begin
                    nxt_state = S_WAIT;
                end
            end
            S_BIT: begin
                if (arb_lost || bit_end) begin
                    nxt_state = S_WAIT;
                end
            end
            S_STOP: begin
                // Stop followed straight by a start when both asked
                if (stop_end) begin
                    nxt_state = ctrl_ff.start ? S_START : S_IDLE;
                end
            end
            S_WAIT: begin
                if (go) begin
                    if (is_addr) begin
                        nxt_state = S_BIT;
                    end else if (is_arb) begin
                        nxt_state = ctrl_ff.start ? S_START : S_IDLE;
                    end else if (ctrl_ff.stop) begin
                        nxt_state = S_STOP;
                    end else if (ctrl_ff.start) begin
                        nxt_state = S_START;
                    end else if (is_rx) begin
                        nxt_state = S_BIT;
                    end else begin
                        // No transmit data path here: end the frame
                        nxt_state = S_STOP;
                    end
                end
            end
        endcase
        if (!ctrl_ff.en) begin
            nxt_state = S_IDLE;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Pin drive, data changes are held one cycle past a clock edge
    always_comb begin
        nxt_scl_oe = 1'b0;
        nxt_sda_oe = 1'b0;
        unique case (state_ff)
            S_IDLE: begin
                nxt_scl_oe = 1'b0;
                nxt_sda_oe = 1'b0;
            end
            S_START: begin
                nxt_scl_oe = owner_ff && (ph_ff == 2'h0);
                nxt_sda_oe = fresh ? sda_oe_ff : ph_ff[1];
            end
            S_BIT: begin
                nxt_scl_oe = !ph_ff[1];
                nxt_sda_oe = fresh ? sda_oe_ff : !send_one;
            end
            S_STOP: begin
                nxt_scl_oe = !ph_ff[1];
                nxt_sda_oe = fresh ? sda_oe_ff : (ph_ff != PH_LAST);
            end
            S_WAIT: begin
                // Clock held low while software handles the step, if we still own the bus
                nxt_scl_oe = owner_ff;
                nxt_sda_oe = sda_oe_ff && owner_ff;
            end
        endcase
        if (arb_lost || !ctrl_ff.en) begin
            nxt_scl_oe = 1'b0;
            nxt_sda_oe = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Control register; hardware set of the flag wins over a clear
    always_comb begin
        nxt_ctrl = ctrl_ff;
        if (wr_ctrl) begin
            nxt_ctrl      = wctrl;
            nxt_ctrl.flag = ctrl_ff.flag && !wctrl.flag;
            nxt_ctrl.wcol = ctrl_ff.wcol;
            nxt_ctrl.rsvd = 1'b0;
        end
        if (stop_end) begin
            nxt_ctrl.stop = 1'b0;
        end
        if (wr_data) begin
            nxt_ctrl.wcol = !ctrl_ff.flag;
        end
        if (flag_set) begin
            nxt_ctrl.flag = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Pin synchronisers and bus monitor
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            sync1_ff <= 2'h3;
            sync2_ff <= 2'h3;
            prev_ff  <= 2'h3;
        end else begin
            sync1_ff <= {scl_i, sda_i};
            sync2_ff <= sync1_ff;
            prev_ff  <= sync2_ff;
        end
    end

    // Data falling with clock high marks START, rising marks STOP
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            busy_ff <= 1'b0;
        end else if (scl_s && prev_ff[1] && prev_ff[0] && !sda_s) begin
            busy_ff <= 1'b1;
        end else if (scl_s && prev_ff[1] && !prev_ff[0] && sda_s) begin
            busy_ff <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Registers and pins
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state_ff  <= S_IDLE;
            ctrl_ff   <= twm_ctrl_t'(CTRL_RST);
            scl_oe_ff <= 1'b0;
            sda_oe_ff <= 1'b0;
            rdata_ff  <= 8'h00;
            presc_ff  <= 2'h0;
        end else begin
            state_ff  <= nxt_state;
            ctrl_ff   <= nxt_ctrl;
            scl_oe_ff <= nxt_scl_oe;
            sda_oe_ff <= nxt_sda_oe;
            rdata_ff  <= reg_rd ? rd_mux : 8'h00;
            presc_ff  <= wr_stat ? reg_wdata[1:0] : presc_ff;
        end
    end

    // Data register: software load only while the flag is set
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            data_ff <= DATA_RST;
        end else if (rx_data) begin
            data_ff <= shreg_ff;
        end else if (wr_data && ctrl_ff.flag) begin
            data_ff <= reg_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Bit engine: four quarters per bit, sample in the third
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            cnt_ff   <= 16'h0000;
            ph_ff    <= 2'h0;
            bit_ff   <= 4'h0;
            shreg_ff <= 8'h00;
            samp_ff  <= 1'b1;
            addr_ff  <= 1'b0;
        end else if (nxt_state != state_ff) begin
            cnt_ff   <= 16'h0000;
            ph_ff    <= 2'h0;
            bit_ff   <= 4'h0;
            shreg_ff <= ld_addr ? data_ff : shreg_ff;
            addr_ff  <= ld_addr;
        end else if (tick) begin
            cnt_ff  <= 16'h0000;
            ph_ff   <= ph_ff + 2'h1;
            samp_ff <= samp_now ? sda_s : samp_ff;
            if (ph_ff == PH_LAST) begin
                bit_ff   <= bit_ff + 4'h1;
                shreg_ff <= {shreg_ff[6:0], samp_ff};
            end
        end else if (run) begin
            cnt_ff <= cnt_ff + 16'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Status code, direction and ownership
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            code_ff  <= SC_IDLE;
            owner_ff <= 1'b0;
            rd_ff    <= 1'b0;
        end else if (!ctrl_ff.en || stop_end) begin
            code_ff  <= SC_IDLE;
            owner_ff <= 1'b0;
        end else if (arb_lost) begin
            code_ff  <= SC_ARB;
            owner_ff <= 1'b0;
        end else if (strt_end) begin
            // Repeated START keeps ownership
            code_ff  <= owner_ff ? SC_RSTART : SC_START;
            owner_ff <= 1'b1;
        end else if (bit_end && addr_ff) begin
            if (rd_ff) begin
                code_ff <= samp_ff ? SC_RA_NAK : SC_RA_ACK;
            end else begin
                code_ff <= samp_ff ? SC_WA_NAK : SC_WA_ACK;
            end
        end else if (rx_data) begin
            code_ff <= ctrl_ff.ack_en ? SC_RD_ACK : SC_RD_NAK;
        end else if (go && is_arb && !ctrl_ff.start) begin
            code_ff <= SC_IDLE;
        end else if (ld_addr) begin
            rd_ff <= data_ff[0];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks
    property p_start_code;
        @(posedge clk_sys) disable iff (!arst_n)
        (strt_end && !owner_ff && ctrl_ff.en) |=> (ctrl_ff.flag && code_ff == SC_START);
    endproperty
    a_start_code: assert property (p_start_code) else $error("no 0x08 after START");

    property p_rstart_code;
        @(posedge clk_sys) disable iff (!arst_n)
        (strt_end && owner_ff && ctrl_ff.en) |=> (owner_ff && code_ff == SC_RSTART);
    endproperty
    a_rstart_code: assert property (p_rstart_code) else $error("bad repeated START");

    property p_flag_clear;
        @(posedge clk_sys) disable iff (!arst_n)
        (wr_ctrl && wctrl.flag && state_ff == S_WAIT) |=> !ctrl_ff.flag;
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");

    property p_stop_clr;
        @(posedge clk_sys) disable iff (!arst_n)
        (stop_end && !wr_ctrl) |=> (!ctrl_ff.stop && !owner_ff);
    endproperty
    a_stop_clr: assert property (p_stop_clr) else $error("stop request kept");

    property p_hold_scl;
        @(posedge clk_sys) disable iff (!arst_n)
        (state_ff == S_WAIT && owner_ff && ctrl_ff.en) [*2] |-> scl_oe;
    endproperty
    a_hold_scl: assert property (p_hold_scl) else $error("clock not held");

    property p_irq_drop;
        @(posedge clk_sys) disable iff (!arst_n)
        (wr_ctrl && wctrl.flag && state_ff == S_WAIT) |=> !irq;
    endproperty
    a_irq_drop: assert property (p_irq_drop) else $error("irq kept");

    property p_raddr_code;
        @(posedge clk_sys) disable iff (!arst_n)
        (bit_end && addr_ff && rd_ff && ctrl_ff.en)
        |=> (ctrl_ff.flag && (code_ff == SC_RA_ACK || code_ff == SC_RA_NAK));
    endproperty
    a_raddr_code: assert property (p_raddr_code) else $error("bad read address code");

    property p_ack_drive;
        @(posedge clk_sys) disable iff (!arst_n)
        (state_ff == S_BIT && !addr_ff && in_ack && ph_ff == 2'h1 && !fresh)
        |=> (sda_oe == ctrl_ff.ack_en);
    endproperty
    a_ack_drive: assert property (p_ack_drive) else $error("wrong ack drive");

    property p_bus_wait;
        @(posedge clk_sys) disable iff (!arst_n)
        (state_ff == S_START && !owner_ff && busy_ff) |=> (cnt_ff == $past(cnt_ff));
    endproperty
    a_bus_wait: assert property (p_bus_wait) else $error("START on busy bus");

    property p_rx_data;
        @(posedge clk_sys) disable iff (!arst_n)
        rx_data |=> (data_ff == $past(shreg_ff) && ctrl_ff.flag);
    endproperty
    a_rx_data: assert property (p_rx_data) else $error("byte not stored");

endmodule : twm_master_rx

// file: dv/twm_slave_model.sv
// Behavioural slave transmitter that answers the master on the wired-AND bus
module twm_slave_model #(
    parameter logic [6:0] ADDR = 7'h52  // Device address this model answers
)(
    input  wire logic       scl,
    input  wire logic       sda,
    input  wire logic [7:0] first_byte,
    input  wire logic       stretch,
    output logic            scl_pull,
    output logic            sda_pull,
    output logic            last_ack
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] shreg;                  // Address byte as shifted in
    logic [7:0] tx;                     // Byte being sent
    logic       go;                     // Selected, or master still acking
    ////////////////////////////////////////////////////////////////////////////
    // One frame per START; released lines float high through the pull-up
    initial begin
        scl_pull = 1'b0;
        sda_pull = 1'b0;
        last_ack = 1'b0;
        forever begin
            @(negedge sda iff scl === 1'b1);
            for (int i = 0; i < 8; i++) begin
                @(posedge scl);
                shreg = {shreg[6:0], sda};
            end
            go = (shreg[7:1] == ADDR) && shreg[0];
            @(negedge scl);
            if (go) begin
                // Acknowledge, then send bytes while the master acks them
                sda_pull = 1'b1;
                @(negedge scl);
                tx = first_byte;
                while (go) begin
                    for (int b = 7; b >= 0; b--) begin
                        sda_pull = ~tx[b];
                        // Slow answer: stretch the clock in mid byte
                        if (stretch && b == 3) begin
                            scl_pull = 1'b1;
                            #1000;
                            scl_pull = 1'b0;
                        end
                        @(negedge scl);
                    end
                    sda_pull = 1'b0;
                    @(posedge scl);
                    last_ack = ~sda;
                    go = ~sda;
                    tx = tx + 8'h01;
                    @(negedge scl);
                end
            end
            sda_pull = 1'b0;
        end
    end
endmodule : twm_slave_model

// file: dv/two_wire_master_receiver_tb_top.sv
// Self-checking bench for the master receiver with a slave model on the bus
module two_wire_master_receiver_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import twm_pkg::*;
    localparam logic [6:0] ADDR = 7'h52;    // Address of the slave model
    logic       clk_sys, arst_n, reg_wr, reg_rd, irq;
    logic [1:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, first_byte, v;
    logic       scl_o, scl_oe, sda_o, sda_oe, scl_pull, sda_pull;
    logic       tb_sda_pull, stretch, last_ack;
    wire        scl = ~(scl_oe | scl_pull);  // Wired-AND with pull-up
    wire        sda = ~(sda_oe | sda_pull | tb_sda_pull);
    int         n_mismatch, n_compared;
    logic [31:0] seed;                       // Xorshift state
    byte unsigned exp_q[$];                  // Bytes the slave is expected to send
    twm_master_rx #(.QCYC(2)) u_twm_master_rx (
        .clk_sys(clk_sys), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
        .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe),
        .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe));
    twm_slave_model #(.ADDR(ADDR)) u_twm_slave_model (
        .scl(scl), .sda(sda), .first_byte(first_byte), .stretch(stretch),
        .scl_pull(scl_pull), .sda_pull(sda_pull), .last_ack(last_ack));
    always #25 clk_sys = ~clk_sys;
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    // Bus cycles start right after a rising edge; a gap edge follows a write
    task automatic reg_write(input logic [1:0] a, input logic [7:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        @(posedge clk_sys);
    endtask : reg_write
    task automatic reg_read(input logic [1:0] a, output logic [7:0] d);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
        @(posedge clk_sys);
    endtask : reg_read
    // Write control, wait for the flag (or idle after STOP) within a bound
    task automatic step(input logic [7:0] c, input logic [7:0] exp);
        logic [7:0] r;
        int         k;
        reg_write(OFF_CTRL, c);
        r = 8'h00;
        for (k = 0; k < 3000 && !(exp == SC_IDLE ? (r & 8'hF8) == SC_IDLE : r[7]); k++)
            reg_read(exp == SC_IDLE ? OFF_STAT : OFF_CTRL, r);
        reg_read(OFF_STAT, r);
        check(r & 8'hF8, exp);
        if (exp == SC_IDLE) begin
            reg_read(OFF_CTRL, r);
            check(r, {5'h00, c[2], 1'b0, c[0]});
        end else begin
            check({7'h00, irq}, {7'h00, c[0]});
            if (exp != SC_ARB) check({7'h00, scl}, 8'h00);
        end
    endtask : step
    // Receive n bytes, acking all but the last, and compare with the model
    task automatic recv(input int n);
        logic [7:0] d;
        for (int i = 0; i < n; i++) exp_q.push_back(first_byte + i[7:0]);
        for (int i = 0; i < n; i++) begin
            step(i < n - 1 ? 8'hC5 : 8'h85, i < n - 1 ? SC_RD_ACK : SC_RD_NAK);
            reg_read(OFF_DATA, d);
            check(d, exp_q.pop_front());
            check({7'h00, last_ack}, {7'h00, i < n - 1});
        end
    endtask : recv
    task automatic final_report;
        $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : final_report
    ////////////////////////////////////////////////////////////////////////////
    // Watchdog sized well above the expected run length
    initial begin
        #3000000;
        n_mismatch++;
        final_report();
    end
    initial begin
        {clk_sys, arst_n, reg_wr, reg_rd, tb_sda_pull, stretch} = 6'h00;
        reg_addr = 2'h0;
        reg_wdata = 8'h00;
        first_byte = 8'h00;
        seed = 32'd18;
        repeat (8) @(posedge clk_sys);
        arst_n <= 1'b1;
        @(posedge clk_sys);
        // Reset values, unmapped place, prescaler storage, refused data write
        reg_read(OFF_CTRL, v); check(v, CTRL_RST);
        reg_read(OFF_STAT, v); check(v, SC_IDLE);
        reg_read(OFF_DATA, v); check(v, DATA_RST);
        reg_read(2'h3, v); check(v, 8'h00);
        reg_write(OFF_STAT, 8'h03);
        reg_read(OFF_STAT, v); check(v, 8'hFB);
        reg_write(OFF_STAT, 8'h00);
        reg_write(OFF_DATA, 8'h11);
        reg_read(OFF_CTRL, v); check(v, 8'h08);
        // Open-drain outputs only ever pull low, and nothing pulls while idle
        check({4'h0, scl_o, sda_o, scl_oe, sda_oe}, 8'h00);
        $display("test registers done");
        // Read, repeated START, slower second read, then STOP
        for (int t = 0; t < 2; t++) begin
            seed = xs(seed);
            first_byte <= seed[7:0];
            stretch <= t[0];
            step(8'hA5, t ? SC_RSTART : SC_START);
            reg_write(OFF_DATA, {ADDR, 1'b1});
            step(8'h85, SC_RA_ACK);
            recv(int'(seed[9:8]) + 1);
        end
        step(8'h95, SC_IDLE);
        $display("test read and repeated start done");
        // Unknown address, then STOP followed by START
        step(8'hA5, SC_START);
        reg_write(OFF_DATA, 8'hB1);
        step(8'h85, SC_RA_NAK);
        step(8'hB5, SC_START);
        reg_write(OFF_DATA, {ADDR, 1'b1});
        step(8'h85, SC_RA_ACK);
        recv(1);
        step(8'h95, SC_IDLE);
        $display("test address nack done");
        // Another master holds data low during the address
        step(8'hA4, SC_START);
        reg_write(OFF_DATA, {ADDR, 1'b1});
        tb_sda_pull <= 1'b1;
        step(8'h84, SC_ARB);
        repeat (20) @(posedge clk_sys);
        tb_sda_pull <= 1'b0;
        step(8'hA4, SC_START);
        // A flag clear after START always sends the loaded address, so the
        // STOP has to wait for the address step; the slave ignores writes
        reg_write(OFF_DATA, {ADDR, 1'b0});
        step(8'h84, SC_WA_NAK);
        step(8'h94, SC_IDLE);
        $display("test arbitration done");
        final_report();
    end
endmodule : two_wire_master_receiver_tb_top
